// >>> design/np_capture_pkg.sv
package np_capture_pkg;

  // register map
  localparam logic [4:0]  REG_PARTNER_ABILITY = 5'h05;
  localparam logic [15:0] PARTNER_RESET       = 16'h0000;

  // field positions of the captured next page
  localparam int BIT_MORE_PAGES = 15;
  localparam int BIT_ACK        = 14;
  localparam int BIT_MSG_PAGE   = 13;
  localparam int BIT_COMPLY     = 12;
  localparam int BIT_TOGGLE     = 11;
  localparam int CODE_W         = 11;

  // one received link code word, as handed over by negotiation
  typedef struct packed {
    logic              more_pages_request;
    logic              ack;
    logic              message_page_flag;
    logic              comply_acknowledge;
    logic              toggle;
    logic [CODE_W-1:0] code;
  } next_page_t;

  // management register request
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } mgmt_req_t;

endpackage

// >>> design/page_latch.sv
`timescale 1ns/1ps
module page_latch
  import np_capture_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // captured word in
  input  wire logic       load,
  input  wire next_page_t page_in,
  // held word out
  output next_page_t      page_q
);

  next_page_t page_d;

  // only negotiation may load; nothing on the management side reaches here
  always_comb begin
    page_d = page_q;
    if (load) begin
      page_d = page_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      page_q <= next_page_t'(PARTNER_RESET);
    end else begin
      page_q <= page_d;
    end
  end

endmodule

// >>> design/partner_next_page_capture.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - bit 15 reads 1 when partner wants another next page.
// - bit 14 reads 1 when partner acknowledged our data word.
// - negotiation updates acknowledge from incoming pulse bursts, no software.
// - bit 13 is 1 for message page, 0 for unformatted.
// - bit 12 reads 1 when partner can comply with message.
// - bit 11 holds partner toggle value as received.
// - bits 10:0 hold code field, zero after reset.
// - code is message code if bit 13 set, else unformatted data.
// - register overwritten with next page after negotiation if next pages supported.
module partner_next_page_capture
  import np_capture_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // from negotiation engine
  input  wire logic        page_valid,
  input  wire next_page_t  page_rx,
  input  wire logic        np_supported,
  input  wire logic        neg_success,
  // management port
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // decoded view of the held page
  output logic             is_message_q,
  output logic [10:0]      code_q
);

  next_page_t held;
  logic       load;
  logic [15:0] rdata_d;
  logic        is_message_d;
  logic [10:0] code_d;
  logic        read_hit;

  // address decode shared by the read path and its checks
  function automatic logic partner_hit(input logic rd_s, input logic [4:0] a);
    return rd_s && (a == REG_PARTNER_ABILITY);
  endfunction

  // flatten the held page into the register layout
  // kept explicit per field so a struct reorder cannot silently move bits
  function automatic logic [15:0] page_word(input next_page_t p);
    logic [15:0] w;
    w                 = 16'h0000;
    w[BIT_MORE_PAGES] = p.more_pages_request;
    w[BIT_ACK]        = p.ack;
    w[BIT_MSG_PAGE]   = p.message_page_flag;
    w[BIT_COMPLY]     = p.comply_acknowledge;
    w[BIT_TOGGLE]     = p.toggle;
    w[CODE_W-1:0]     = p.code;
    return w;
  endfunction

  // one decode for the read path and the checks that use read_hit
  assign read_hit = partner_hit(rd, addr);

  // load only once negotiation has succeeded and next pages are allowed
  assign load = page_valid && neg_success && np_supported;

  page_latch u_latch (
    .clk     (clk),
    .rst     (rst),
    .load    (load),
    .page_in (page_rx),
    .page_q  (held)
  );

  // read path; writes are decoded nowhere, so they have no effect
  always_comb begin
    rdata_d = 16'h0000;
    // rdata is zero outside a read so stale words never linger on the bus
    if (read_hit) begin
      rdata_d = page_word(held);
    end
  end

  // interpretation of code field follows the page type
  always_comb begin
    is_message_d = held.message_page_flag;
    code_d       = held.code;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata        <= 16'h0000;
      is_message_q <= 1'b0;
      code_q       <= 11'h000;
    end else begin
      rdata        <= rdata_d;
      is_message_q <= is_message_d;
      code_q       <= code_d;
    end
  end

  // write never alters the held page
  write_ignored_a: assert property (@(posedge clk) disable iff (rst)
    (wr && !load) |=> (held == $past(held)))
    else $error("write changed captured page");

  capture_load_a: assert property (@(posedge clk) disable iff (rst)
    load |=> (held == $past(page_rx)))
    else $error("page not captured");

  no_load_hold_a: assert property (@(posedge clk) disable iff (rst)
    !load |=> $stable(held))
    else $error("page changed without load");

  read_fields_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == REG_PARTNER_ABILITY) |=> (rdata == $past(held)))
    else $error("read data wrong");

  read_ack_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == REG_PARTNER_ABILITY) |=> (rdata[14] == $past(held.ack)))
    else $error("ack bit wrong");

  read_unmapped_a: assert property (@(posedge clk) disable iff (rst)
    !(rd && addr == REG_PARTNER_ABILITY) |=> (rdata == 16'h0000))
    else $error("unmapped read not zero");

  msg_view_a: assert property (@(posedge clk) disable iff (rst)
    load |=> ##1 (is_message_q == $past(page_rx.message_page_flag, 2)))
    else $error("message flag view wrong");

  toggle_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == REG_PARTNER_ABILITY) |=> (rdata[11] == $past(held.toggle)))
    else $error("toggle bit wrong");

  // per-field read checks for bits 15, 13, 12 and 10:0; ack and toggle reads are checked above

  more_read_a: assert property (@(posedge clk) disable iff (rst)
    read_hit |=> (rdata[15] == $past(held.more_pages_request)))
    else $error("more pages bit wrong");

  msg_read_a: assert property (@(posedge clk) disable iff (rst)
    read_hit |=> (rdata[13] == $past(held.message_page_flag)))
    else $error("message page bit wrong");

  comply_read_a: assert property (@(posedge clk) disable iff (rst)
    read_hit |=> (rdata[12] == $past(held.comply_acknowledge)))
    else $error("comply bit wrong");

  code_read_a: assert property (@(posedge clk) disable iff (rst)
    read_hit |=> (rdata[10:0] == $past(held.code)))
    else $error("code field wrong");

  // reset clears everything visible, without regard to the bus

  reset_clear_a: assert property (@(posedge clk)
    rst |=> ((held == '0) && (rdata == 16'h0000) && !is_message_q && (code_q == 11'h000)))
    else $error("reset did not clear");

  // capture checks for the ack, more pages and toggle fields that negotiation hands over

  ack_load_a: assert property (@(posedge clk) disable iff (rst)
    load |=> (held.ack == $past(page_rx.ack)))
    else $error("ack not captured");

  more_load_a: assert property (@(posedge clk) disable iff (rst)
    load |=> (held.more_pages_request == $past(page_rx.more_pages_request)))
    else $error("more pages not captured");

  toggle_load_a: assert property (@(posedge clk) disable iff (rst)
    load |=> (held.toggle == $past(page_rx.toggle)))
    else $error("toggle not captured");

  // a page without both qualifiers must leave the register alone
  unqual_hold_a: assert property (@(posedge clk) disable iff (rst)
    (page_valid && !(neg_success && np_supported)) |=> $stable(held))
    else $error("unqualified page captured");

  // decoded view lags the held page by one cycle

  code_view_a: assert property (@(posedge clk) disable iff (rst)
    load |=> ##1 (code_q == $past(page_rx.code, 2)))
    else $error("code view wrong");

  msg_track_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (is_message_q == $past(held.message_page_flag)))
    else $error("message view lags wrong");

  code_track_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (code_q == $past(held.code)))
    else $error("code view lags wrong");

  // a write on its own never puts anything on the read bus
  write_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (wr && !read_hit) |=> (rdata == 16'h0000))
    else $error("write produced read data");

endmodule

// >>> dv/link_partner.sv
`timescale 1ns/1ps
module link_partner
  import np_capture_pkg::*;
(
  // clock
  input  wire logic clk,
  // toward capture
  output logic       pv,
  output next_page_t pg,
  output logic       ns,
  output logic       ok
);
  initial begin
    pv = 1'b0;
    pg = '0;
    ns = 1'b0;
    ok = 1'b0;
  end
  // one word per call; afterwards the word is inverted so stale data never looks valid
  task automatic send(input next_page_t p, input logic s, input logic g);
    @(posedge clk);
    pv <= 1'b1;
    pg <= p;
    ns <= s;
    ok <= g;
    @(posedge clk);
    pv <= 1'b0;
    pg <= ~p;
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import np_capture_pkg::*;
  logic        clk, rst, pv, ns, ok, wr, rd, msg;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic [10:0] code;
  next_page_t  pg;
  int          err_count, total_checks;
  localparam logic [15:0] W [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                    16'h0800, 16'h07ff, 16'h2555};
  link_partner lp_u (.clk(clk), .pv(pv), .pg(pg), .ns(ns), .ok(ok));
  partner_next_page_capture dut_u (.clk(clk), .rst(rst), .page_valid(pv), .page_rx(pg),
    .np_supported(ns), .neg_success(ok), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .is_message_q(msg), .code_q(code));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // data is only valid in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // run needs about 45 cycles
  initial begin
    repeat (400) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(REG_PARTNER_ABILITY, PARTNER_RESET);
    foreach (W[i]) begin
      lp_u.send(W[i], 1'b1, 1'b1);
      rd_reg(REG_PARTNER_ABILITY, W[i]);
      chk("msg", {15'h0000, W[i][13]}, {15'h0000, msg});
      chk("code", {5'h00, W[i][10:0]}, {5'h00, code});
    end
    lp_u.send(16'hffff, 1'b0, 1'b1);
    lp_u.send(16'hffff, 1'b1, 1'b0);
    wr_reg(REG_PARTNER_ABILITY, 16'hbfff);
    rd_reg(REG_PARTNER_ABILITY, 16'h2555);
    rd_reg(5'h06, 16'h0000);
    test_done();
  end
endmodule
